//--- verilog/tpu_pkg.sv
package tpu_pkg;
  // Register byte offsets
  localparam logic [7:0] SC_OFS        = 8'h00;
  localparam logic [7:0] CNT_OFS       = 8'h04;
  localparam logic [7:0] MOD_OFS       = 8'h08;
  localparam logic [7:0] FLAG_OFS      = 8'h0c;
  localparam logic [7:0] CH_BASE       = 8'h10;
  localparam logic [7:0] CH_STRIDE     = 8'h08;
  localparam logic [7:0] CH_VAL_OFS    = 8'h04;
  // Status and control fields
  localparam int PS_LSB   = 0;
  localparam int CSS_LSB  = 3;
  localparam int CENTER_PWM_SELECT_BIT = 5;
  localparam int TOIE_BIT = 7;
  // Channel control fields
  localparam int MS_LSB   = 0;
  localparam int ELS_LSB  = 2;
  localparam int CHIE_BIT = 4;
  // Flag register: overflow bit above channels
  localparam int OVF_BIT  = 8;
  // Counter constants
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [6:0]  PRE_ONE  = 7'h01;
  // Clock source select codes
  localparam logic [1:0] CSS_OFF = 2'h0;
  localparam logic [1:0] CSS_BUS = 2'h1;
  localparam logic [1:0] CSS_FIX = 2'h2;
  localparam logic [1:0] CSS_EXT = 2'h3;
  // Channel mode select codes (bit 1 set means edge PWM)
  localparam logic [1:0] MS_CAPTURE = 2'h0;
  localparam logic [1:0] MS_COMPARE = 2'h1;
  // Edge and level select codes
  localparam logic [1:0] ELS_NONE   = 2'h0;
  localparam logic [1:0] ELS_RISE   = 2'h1;
  localparam logic [1:0] ELS_FALL   = 2'h2;
  localparam logic [1:0] ELS_BOTH   = 2'h3;
  // Bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
endpackage

//--- verilog/tpu_timer.sv
// Notes on behaviour
// - Direct value writes only in capture mode
// - PWM buffer loads on step to modulo
// - Status write clears pending value buffers
// - Prescaler divides by 1 to 128
// - Bus, synchronised fixed, or external source
// - 16-bit counter, free/modulo, up or up-down
// - One request per channel plus overflow
// - Center bit forces all channels center PWM
// - Debug halt freezes all counting
// - Runs in wait; stop halts clocks
// - Capture edge copies counter, sets flag
// - Compare match sets flag, drives action
// - Edge PWM period modulo plus one
// - Center PWM counts up then down
// - Center: active on down match, inactive up
// - Modulo 0 or ffff means free-running
// - Counter reads never disturb counting
// - Any counter write clears the counter
// - Channel count is parameter, one pin each
// - Pins released when no function enabled
// - External source synchronised, quarter rate max
// - Source select 0 disables timer
// - Capture input synchronised, short pulses lost
`timescale 1ns/10ps
`default_nettype none
module tpu_timer #(
  parameter int unsigned CHANNELS = 8
) (
  input  wire  logic                hclk,
  input  wire  logic                hresetn,
  input  wire  logic                hsel,
  input  wire  logic [31:0]         haddr,
  input  wire  logic [1:0]          htrans,
  input  wire  logic                hwrite,
  input  wire  logic [2:0]          hsize,
  input  wire  logic                hready,
  input  wire  logic [31:0]         hwdata,
  output logic       [31:0]         hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire  logic                fixed_clk_in,
  input  wire  logic                external_count_source,
  input  wire  logic                debug_halt_mode,
  input  wire  logic [CHANNELS-1:0] channel_pin_in,
  output logic       [CHANNELS-1:0] channel_pin_out,
  output logic       [CHANNELS-1:0] channel_pin_oe,
  output logic       [CHANNELS-1:0] chan_irq,
  output logic                      overflow_irq
);
  typedef struct packed {
    logic [7:0]                 addr;
    logic                       wr_pend;
    logic                       rd_pend;
    logic                       ready;
    logic [31:0]                rdata;
    logic [7:0]                 sc;
    logic [15:0]                cnt;
    logic                       down;
    logic [15:0]                modv;
    logic [6:0]                 pre;
    logic                       ovf;
    logic                       ovf_irq;
    logic [2:0]                 sync1;
    logic [2:0]                 sync2;
    logic [1:0]                 prev;
    logic [CHANNELS-1:0]        pin_s1;
    logic [CHANNELS-1:0]        pin_s2;
    logic [CHANNELS-1:0]        pin_prev;
    logic [CHANNELS-1:0][4:0]   ctl;
    logic [CHANNELS-1:0][15:0]  val;
    logic [CHANNELS-1:0][15:0]  buff;
    logic [CHANNELS-1:0]        pend;
    logic [CHANNELS-1:0]        flag;
    logic [CHANNELS-1:0]        pout;
    logic [CHANNELS-1:0]        oe;
    logic [CHANNELS-1:0]        irq;
  } tpu_state_type;

  tpu_state_type s_q;
  tpu_state_type s_d;

  logic        wr_go;
  logic        halt;
  logic        src_edge;
  logic        tick;
  logic [15:0] top;
  logic [15:0] cnt_n;
  logic [6:0]  pre_mask;
  logic [1:0]  css;
  logic        center;
  logic        pwm_load;
  logic [1:0]  ms;
  logic [1:0]  els;
  logic        active;
  logic        edge_hit;
  logic [7:0]  ch_a;

  // Next-state logic for bus slave, counter and channels
  always_comb begin
    s_d      = s_q;
    css      = s_q.sc[tpu_pkg::CSS_LSB +: 2];
    center   = s_q.sc[tpu_pkg::CENTER_PWM_SELECT_BIT];
    halt     = s_q.sync2[2];
    wr_go    = s_q.wr_pend & s_q.ready;
    ms       = tpu_pkg::MS_CAPTURE;
    els      = tpu_pkg::ELS_NONE;
    active   = 1'b0;
    edge_hit = 1'b0;
    ch_a     = tpu_pkg::CH_BASE;
    // Source edge: bus every cycle, others on synchronised rising edge
    case (css)
      tpu_pkg::CSS_BUS: src_edge = 1'b1;
      tpu_pkg::CSS_FIX: src_edge = s_q.sync2[0] & ~s_q.prev[0];
      tpu_pkg::CSS_EXT: src_edge = s_q.sync2[1] & ~s_q.prev[1];
      default:          src_edge = 1'b0;
    endcase
    pre_mask = 7'((8'h01 << s_q.sc[tpu_pkg::PS_LSB +: 3]) - 8'h01);
    // Free-running prescaler tapped by mask; a smaller ratio never stalls it
    tick     = src_edge & ~halt & ((s_q.pre & pre_mask) == pre_mask);
    if (src_edge && !halt) begin
      s_d.pre = s_q.pre + tpu_pkg::PRE_ONE;
    end
    // Modulo 0 or all ones runs free
    top = (s_q.modv == tpu_pkg::CNT_ZERO) ? tpu_pkg::CNT_MAX : s_q.modv;
    pwm_load = tick & ~s_q.down & (s_q.cnt == top - tpu_pkg::CNT_ONE);
    // Counter step: up-wrap, or up then down when centered
    cnt_n = s_q.cnt;
    if (tick) begin
      if (!center) begin
        cnt_n = (s_q.cnt == top) ? tpu_pkg::CNT_ZERO
                                 : s_q.cnt + tpu_pkg::CNT_ONE;
        s_d.down = 1'b0;
      end else if (!s_q.down) begin
        cnt_n    = (s_q.cnt == top) ? s_q.cnt - tpu_pkg::CNT_ONE
                                    : s_q.cnt + tpu_pkg::CNT_ONE;
        s_d.down = (s_q.cnt == top);
      end else begin
        cnt_n    = (s_q.cnt == tpu_pkg::CNT_ZERO) ? tpu_pkg::CNT_ONE
                                                  : s_q.cnt - tpu_pkg::CNT_ONE;
        s_d.down = (s_q.cnt != tpu_pkg::CNT_ZERO);
      end
    end
    s_d.cnt = cnt_n;
    if (tick && cnt_n == tpu_pkg::CNT_ZERO) begin
      s_d.ovf = 1'b1;
    end
    // Synchroniser stages
    s_d.sync1    = {debug_halt_mode, external_count_source, fixed_clk_in};
    s_d.sync2    = s_q.sync1;
    s_d.prev     = s_q.sync2[1:0];
    s_d.pin_s1   = channel_pin_in;
    s_d.pin_s2   = s_q.pin_s1;
    s_d.pin_prev = s_q.pin_s2;
    // Per-channel behaviour
    for (int i = 0; i < CHANNELS; i++) begin
      ms       = s_q.ctl[i][tpu_pkg::MS_LSB +: 2];
      els      = s_q.ctl[i][tpu_pkg::ELS_LSB +: 2];
      active   = (els != tpu_pkg::ELS_NONE) && (css != tpu_pkg::CSS_OFF);
      edge_hit = ((els == tpu_pkg::ELS_RISE) || (els == tpu_pkg::ELS_BOTH))
                 & s_q.pin_s2[i] & ~s_q.pin_prev[i];
      edge_hit = edge_hit | (((els == tpu_pkg::ELS_FALL) || (els == tpu_pkg::ELS_BOTH))
                 & ~s_q.pin_s2[i] & s_q.pin_prev[i]);
      if (center) begin
        // Center PWM on every channel
        if (pwm_load && s_q.pend[i]) begin
          s_d.val[i]  = s_q.buff[i];
          s_d.pend[i] = 1'b0;
        end
        if (tick && active && cnt_n == s_q.val[i]) begin
          s_d.pout[i] = s_d.down ? ~els[0] : els[0];
          s_d.flag[i] = 1'b1;
        end
      end else if (ms == tpu_pkg::MS_CAPTURE) begin
        if (active && edge_hit) begin
          s_d.val[i]  = s_q.cnt;
          s_d.flag[i] = 1'b1;
        end
      end else if (ms == tpu_pkg::MS_COMPARE) begin
        if (s_q.pend[i] && (tick || css == tpu_pkg::CSS_OFF)) begin
          s_d.val[i]  = s_q.buff[i];
          s_d.pend[i] = 1'b0;
        end
        if (tick && cnt_n == s_q.val[i]) begin
          s_d.flag[i] = 1'b1;
          case (els)
            tpu_pkg::ELS_RISE: s_d.pout[i] = ~s_q.pout[i];
            tpu_pkg::ELS_FALL: s_d.pout[i] = 1'b0;
            tpu_pkg::ELS_BOTH: s_d.pout[i] = 1'b1;
            default:           s_d.pout[i] = s_q.pout[i];
          endcase
        end
      end else begin
        // Edge PWM: start of period then duty match
        if (pwm_load && s_q.pend[i]) begin
          s_d.val[i]  = s_q.buff[i];
          s_d.pend[i] = 1'b0;
        end
        if (tick && active && cnt_n == tpu_pkg::CNT_ZERO) begin
          s_d.pout[i] = ~els[0];
          s_d.flag[i] = 1'b1;
        end
        if (tick && active && cnt_n == s_q.val[i]) begin
          s_d.pout[i] = els[0];
          s_d.flag[i] = 1'b1;
        end
      end
      s_d.oe[i] = active && (center || ms != tpu_pkg::MS_CAPTURE);
    end
    // Bus write, data phase; hardware set wins over clear only if the flag was clear
    if (wr_go) begin
      case (s_q.addr)
        tpu_pkg::SC_OFS: begin
          s_d.sc   = hwdata[7:0];
          s_d.pend = '0;
        end
        tpu_pkg::CNT_OFS: begin
          s_d.cnt  = tpu_pkg::CNT_ZERO;
          s_d.down = 1'b0;
          s_d.pre  = 7'h00;
        end
        tpu_pkg::MOD_OFS:  s_d.modv = hwdata[15:0];
        tpu_pkg::FLAG_OFS: begin
          s_d.flag = s_q.flag & ~hwdata[CHANNELS-1:0] | (s_d.flag & ~s_q.flag);
          s_d.ovf  = (s_q.ovf & ~hwdata[tpu_pkg::OVF_BIT]) | (s_d.ovf & ~s_q.ovf);
        end
        default: begin
          for (int i = 0; i < CHANNELS; i++) begin
            ch_a = tpu_pkg::CH_BASE + 8'(i * tpu_pkg::CH_STRIDE);
            if (s_q.addr == ch_a) begin
              s_d.ctl[i] = hwdata[4:0];
            end
            if (s_q.addr == ch_a + tpu_pkg::CH_VAL_OFS) begin
              if (!center && s_q.ctl[i][tpu_pkg::MS_LSB +: 2] == tpu_pkg::MS_CAPTURE) begin
                s_d.val[i]  = hwdata[15:0];
              end else begin
                s_d.buff[i] = hwdata[15:0];
                s_d.pend[i] = 1'b1;
              end
            end
          end
        end
      endcase
    end
    // Interrupt requests from flags and enables
    for (int i = 0; i < CHANNELS; i++) begin
      s_d.irq[i] = s_d.flag[i] & s_d.ctl[i][tpu_pkg::CHIE_BIT];
    end
    s_d.ovf_irq = s_d.ovf & s_d.sc[tpu_pkg::TOIE_BIT];
    // Read data phase: one wait state, then data
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
      s_d.ready   = 1'b1;
      s_d.rdata   = tpu_pkg::RD_ZERO;
      case (s_q.addr)
        tpu_pkg::SC_OFS:   s_d.rdata[7:0]  = s_q.sc;
        tpu_pkg::CNT_OFS:  s_d.rdata[15:0] = s_q.cnt;
        tpu_pkg::MOD_OFS:  s_d.rdata[15:0] = s_q.modv;
        tpu_pkg::FLAG_OFS: begin
          s_d.rdata[CHANNELS-1:0]       = s_q.flag;
          s_d.rdata[tpu_pkg::OVF_BIT]   = s_q.ovf;
        end
        default: begin
          for (int i = 0; i < CHANNELS; i++) begin
            ch_a = tpu_pkg::CH_BASE + 8'(i * tpu_pkg::CH_STRIDE);
            if (s_q.addr == ch_a) begin
              s_d.rdata[4:0] = s_q.ctl[i];
            end
            if (s_q.addr == ch_a + tpu_pkg::CH_VAL_OFS) begin
              s_d.rdata[15:0] = s_q.val[i];
            end
          end
        end
      endcase
    end
    // Address phase capture
    s_d.wr_pend = 1'b0;
    if (hsel && hready && htrans == tpu_pkg::HTRANS_NONSEQ) begin
      s_d.addr    = haddr[7:0];
      s_d.wr_pend = hwrite;
      s_d.rd_pend = ~hwrite;
      s_d.ready   = hwrite;
    end
  end

  // State register, no wait gating: runs while hclk runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q       <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state, except hresp tied low
  assign hrdata          = s_q.rdata;
  assign hreadyout       = s_q.ready;
  assign hresp           = 1'b0;
  assign channel_pin_out = s_q.pout;
  assign channel_pin_oe  = s_q.oe;
  assign chan_irq        = s_q.irq;
  assign overflow_irq    = s_q.ovf_irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_cnt_write;
    wr_go && s_q.addr == tpu_pkg::CNT_OFS;
  endsequence
  sequence s_sc_write;
    wr_go && s_q.addr == tpu_pkg::SC_OFS;
  endsequence

  a_cnt_write_clear: assert property (s_cnt_write |=> s_q.cnt == tpu_pkg::CNT_ZERO)
    else $error("counter not cleared by write");
  a_sc_write_pend: assert property (s_sc_write |=> s_q.pend == '0)
    else $error("status write left buffer pending");
  a_halt_freeze: assert property (s_q.sync2[2] && !wr_go |=> $stable(s_q.cnt))
    else $error("counter moved in debug halt");
  a_cnt_up_step: assert property (tick && !center && !wr_go && s_q.cnt != top
    |=> s_q.cnt == $past(s_q.cnt) + tpu_pkg::CNT_ONE)
    else $error("counter did not step by one");
  a_free_top: assert property (tick && !center && !wr_go
    && (s_q.modv == tpu_pkg::CNT_ZERO || s_q.modv == tpu_pkg::CNT_MAX)
    && s_q.cnt != tpu_pkg::CNT_MAX |=> s_q.cnt != tpu_pkg::CNT_ZERO)
    else $error("free-running counter wrapped early");
  a_off_release: assert property (css == tpu_pkg::CSS_OFF [*2] |-> s_q.oe == '0)
    else $error("pin driven while timer disabled");
  a_div1_tick: assert property (css == tpu_pkg::CSS_BUS && !halt &&
    s_q.sc[tpu_pkg::PS_LSB +: 3] == 3'h0 |-> tick)
    else $error("divide by one missed a tick");

  // Per-channel checks: capture copies counter, PWM buffer loads at modulo
  wire [CHANNELS-1:0] cap_hit;
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan_chk
    assign cap_hit[g] = s_q.ctl[g][tpu_pkg::MS_LSB +: 2] == tpu_pkg::MS_CAPTURE
      && s_q.ctl[g][tpu_pkg::ELS_LSB +: 2] != tpu_pkg::ELS_NONE
      && css != tpu_pkg::CSS_OFF
      && s_q.pin_s2[g] != s_q.pin_prev[g]
      && (s_q.ctl[g][tpu_pkg::ELS_LSB +: 2] == tpu_pkg::ELS_BOTH
          || s_q.ctl[g][tpu_pkg::ELS_LSB +: 2] == {~s_q.pin_s2[g], s_q.pin_s2[g]});
    a_ic_capture: assert property (!center && cap_hit[g] && !wr_go
      |=> s_q.flag[g] && s_q.val[g] == $past(s_q.cnt))
      else $error("capture did not copy counter");
    a_pwm_load: assert property (pwm_load && s_q.pend[g] && !wr_go &&
      (center || s_q.ctl[g][1]) |=> s_q.val[g] == $past(s_q.buff[g]) && !s_q.pend[g])
      else $error("buffered value not loaded at modulo");
  end
endmodule // tpu_timer
`default_nettype wire

//--- test/tpu_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module tpu_pin_model #(
  parameter int CH = 4
) (
  input  wire logic          hclk,
  output var  logic          fixed_clk_in,
  output var  logic          external_count_source,
  output var  logic [CH-1:0] channel_pin_in
);
  int cyc = 0;
  // Quiet pins at time zero
  initial begin
    fixed_clk_in = 1'b0;
    external_count_source = 1'b0;
    channel_pin_in = '0;
  end
  // Fixed clock period 16 cycles, external period 8: under a quarter of bus rate
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7) fixed_clk_in <= ~fixed_clk_in;
    if (cyc % 4 == 3) external_count_source <= ~external_count_source;
  end
  // Capture pulse held six cycles, long enough for the synchroniser
  task automatic pulse(input int ch);
    channel_pin_in[ch] <= 1'b1;
    repeat (6) @(posedge hclk);
    channel_pin_in[ch] <= 1'b0;
  endtask
endmodule // tpu_pin_model
`default_nettype wire

//--- test/timer_pwm_capture_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module timer_pwm_capture_unit_tb;
  logic        hclk, hresetn, hsel, hwrite, dbg;
  logic [31:0] haddr, hwdata, hrdata, r, c1;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, fclk, eclk, ovf;
  logic [3:0]  pin_in, pin_out, pin_oe, irq;
  int          n_errors = 0;
  int          comparisons = 0;
  int          hi, per;
  localparam logic [7:0] FL = tpu_pkg::FLAG_OFS;
  tpu_timer #(.CHANNELS(4)) u_tpu_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fixed_clk_in(fclk), .external_count_source(eclk), .debug_halt_mode(dbg),
    .channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
    .chan_irq(irq), .overflow_irq(ovf));
  tpu_pin_model #(.CH(4)) u_tpu_pin_model (.hclk(hclk), .fixed_clk_in(fclk),
    .external_count_source(eclk), .channel_pin_in(pin_in));
  // Clock only, toggling every 2 ns
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Comparison and reporting
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One AHB-Lite single transfer, entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= tpu_pkg::HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0000_0000);
  endtask
  function automatic logic [31:0] sc(input int css, input int p, input int cp);
    return 32'((css << tpu_pkg::CSS_LSB) | (p << tpu_pkg::PS_LSB) | (cp << tpu_pkg::CENTER_PWM_SELECT_BIT));
  endfunction
  function automatic logic [7:0] ch(input int n, input int v);
    return 8'(tpu_pkg::CH_BASE + tpu_pkg::CH_STRIDE * n + v * tpu_pkg::CH_VAL_OFS);
  endfunction
  // High time and period of one channel output
  task automatic meas(input int n);
    int k;
    k = 0;
    while (pin_out[n] !== 1'b0 && k < 99) begin @(posedge hclk); k++; end
    while (pin_out[n] !== 1'b1 && k < 199) begin @(posedge hclk); k++; end
    hi = 0;
    per = 0;
    while (pin_out[n] === 1'b1 && per < 99) begin @(posedge hclk); per++; hi++; end
    while (pin_out[n] !== 1'b1 && per < 99) begin @(posedge hclk); per++; end
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    int e;
    int srcs[10];
    int divs[10];
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hwdata = '0; dbg = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(tpu_pkg::SC_OFS); chk("status", r, 32'h0000_0000);
    rd(tpu_pkg::CNT_OFS); chk("counter", r, 32'h0000_0000);
    rd(8'hfc); chk("unmapped", r, 32'h0000_0000);
    chk("oe reset", {28'h0, pin_oe}, 32'h0000_0000);
    $display("test reset done");
    // Source and divider table: bus at every tap, then fixed and external
    for (int i = 0; i < 10; i++) begin
      srcs[i] = (i < 8) ? 1 : i - 6;
      divs[i] = (i < 8) ? (1 << i) : (i == 8 ? 16 : 8);
      wr(tpu_pkg::SC_OFS, sc(srcs[i], (i < 8) ? i : 0, 0));
      wr(tpu_pkg::CNT_OFS, 32'hffff_ffff);
      repeat (512) @(posedge hclk);
      wr(tpu_pkg::SC_OFS, 32'h0000_0000);
      rd(tpu_pkg::CNT_OFS);
      e = 514 / divs[i];
      chk("tick count", {31'h0, (r + 2 >= e && r <= e + 2)}, 32'h1);
    end
    $display("test prescaler done");
    wr(tpu_pkg::MOD_OFS, 32'h0000_0005);
    wr(tpu_pkg::CNT_OFS, 32'h0000_0000);
    wr(tpu_pkg::SC_OFS, sc(1, 0, 0) | (32'h1 << tpu_pkg::TOIE_BIT));
    repeat (4) begin
      rd(tpu_pkg::CNT_OFS); chk("below modulo", {31'h0, r <= 32'h5}, 32'h1);
    end
    rd(FL); chk("overflow flag", r & 32'h100, 32'h100);
    chk("overflow irq", {31'h0, ovf}, 32'h1);
    $display("test modulo done");
    wr(tpu_pkg::SC_OFS, 32'h0000_0000);
    wr(tpu_pkg::MOD_OFS, 32'h0000_0000);
    for (int s = 3; s >= 2; s--) begin
      wr(ch(0, 0), 32'((1 << tpu_pkg::CHIE_BIT) | (s << tpu_pkg::ELS_LSB) | 1));
      wr(ch(0, 1), 32'h0000_0003);
      wr(FL, 32'h0000_01ff);
      wr(tpu_pkg::CNT_OFS, 32'h0000_0000);
      wr(tpu_pkg::SC_OFS, sc(1, 0, 0));
      repeat (10) @(posedge hclk);
      chk("compare pin", {31'h0, pin_out[0]}, 32'(s - 2));
      chk("compare oe", {31'h0, pin_oe[0]}, 32'h1);
      chk("compare irq", {31'h0, irq[0]}, 32'h1);
      wr(tpu_pkg::SC_OFS, 32'h0000_0000);
      wr(FL, 32'h0000_0001);
      repeat (3) @(posedge hclk);
      chk("irq cleared", {31'h0, irq[0]}, 32'h0);
    end
    $display("test compare done");
    wr(tpu_pkg::SC_OFS, sc(1, 0, 0));
    dbg <= 1'b1;
    repeat (6) @(posedge hclk);
    rd(tpu_pkg::CNT_OFS); c1 = r;
    repeat (10) @(posedge hclk);
    rd(tpu_pkg::CNT_OFS); chk("halted count", r, c1);
    wr(ch(1, 0), 32'(tpu_pkg::ELS_RISE << tpu_pkg::ELS_LSB));
    wr(ch(1, 1), 32'h0000_1234);
    rd(ch(1, 1)); chk("capture direct", r, 32'h0000_1234);
    u_tpu_pin_model.pulse(1);
    repeat (8) @(posedge hclk);
    rd(ch(1, 1)); chk("captured", r, c1);
    rd(FL); chk("capture flag", r & 32'h2, 32'h2);
    chk("capture oe", {31'h0, pin_oe[1]}, 32'h0);
    $display("test capture done");
    wr(tpu_pkg::MOD_OFS, 32'h0000_0009);
    wr(tpu_pkg::CNT_OFS, 32'h0000_0000);
    wr(ch(2, 0), 32'((tpu_pkg::ELS_FALL << tpu_pkg::ELS_LSB) | 2));
    wr(ch(2, 1), 32'h0000_0004);
    rd(ch(2, 1)); chk("pwm held", r, 32'h0000_0000);
    wr(tpu_pkg::SC_OFS, sc(1, 0, 0));
    dbg <= 1'b0;
    repeat (30) @(posedge hclk);
    rd(ch(2, 1)); chk("buffer dropped", r, 32'h0000_0000);
    wr(ch(2, 1), 32'h0000_0004);
    repeat (30) @(posedge hclk);
    rd(ch(2, 1)); chk("pwm loaded", r, 32'h0000_0004);
    meas(2);
    chk("edge high", 32'(hi), 32'h4);
    chk("edge period", 32'(per), 32'ha);
    $display("test edge pwm done");
    wr(tpu_pkg::SC_OFS, sc(1, 0, 1));
    wr(tpu_pkg::MOD_OFS, 32'h0000_0008);
    wr(tpu_pkg::CNT_OFS, 32'h0000_0000);
    wr(ch(2, 1), 32'h0000_0004);
    repeat (40) @(posedge hclk);
    meas(2);
    chk("center high", 32'(hi), 32'h8);
    chk("center period", 32'(per), 32'h10);
    chk("center forces oe", {31'h0, pin_oe[1]}, 32'h1);
    $display("test center pwm done");
    wr(tpu_pkg::SC_OFS, 32'h0000_0000);
    repeat (4) @(posedge hclk);
    chk("oe released", {28'h0, pin_oe}, 32'h0000_0000);
    rd(tpu_pkg::CNT_OFS); c1 = r;
    repeat (10) @(posedge hclk);
    rd(tpu_pkg::CNT_OFS); chk("off count", r, c1);
    $display("test disable done");
    print_verdict();
  end
endmodule // timer_pwm_capture_unit_tb
`default_nettype wire
